//--- logic/tmr_timer2.v
// timer with 16-bit and split 8-bit auto-reload and slow-oscillator capture, Avalon-MM slave
`timescale 1ns/1ps
`include "tmr_timer2_regs.vh"

// What this block does
// - sixteen-bit count from two software-accessible bytes
// - mode chosen by split, capture-enable, capture-source bits
// - clock sources: core, core/12, external/8
// - external/8 tick synchronised to core clock
// - sixteen-bit mode reloads both bytes on wrap
// - full wrap sets high overflow flag
// - timer interrupt on sixteen-bit overflow when timer interrupt enable set
// - low-byte wrap interrupts when low enable and timer interrupt enable set
// - split mode: two independent eight-bit reload counters
// - split mode: run gates only the high byte
// - per-byte clock select with external select
// - split mode: each byte wrap sets its flag
// - split interrupts: high if timer enable set, low also needs low enable
// - flags cleared only by software writes
// - capture event is slow oscillator falling edge
// - capture unsplit: free wrap, copy count to reload
// - capture split: bytes wrap freely, copy both
// - capture event requests interrupt when enabled
// - sixteen-bit count and split high byte count only while run bit is one
module tmr_timer2 (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // Avalon-MM register slave
   input wire [4:0] address,
   input wire read,
   input wire write,
   input wire [31:0] writedata,
   input wire [3:0] byteenable,
   output reg [31:0] readdata,
   output wire waitrequest,
   // oscillator pins, asynchronous to clk
   input wire extOsc,
   input wire slowOscillator,
   // timer interrupt request, level
   output wire timerIrq
);

   // picks a byte's count pulse from its select bits
   function selTick;
      input clockSelect;
      input externalSelect;
      input sysTick;
      input extTick;
      begin
         if (clockSelect)
            selTick = 1'b1;
         else if (externalSelect)
            selTick = extTick;
         else
            selTick = sysTick;
      end
   endfunction

   // a byte at its top value wraps on its next step
   function atTop;
      input [7:0] value;
      begin
         atTop = (value == 8'hFF);
      end
   endfunction

   // one count step of a byte, wrapping past the top
   function [7:0] stepByte;
      input [7:0] value;
      begin
         stepByte = value + 8'h01;
      end
   endfunction

   // write strobe for one register word
   function wrHit;
      input [4:0] addr;
      input [4:0] target;
      input strobe;
      begin
         wrHit = strobe & (addr == target);
      end
   endfunction

   // registers
   reg [7:0] countLow_r;
   reg [7:0] countHigh_r;
   reg [7:0] reloadLow_r;
   reg [7:0] reloadHigh_r;
   reg highOverflowFlag_r;
   reg lowOverflowFlag_r;
   reg lowByteIrqEnable_r;
   reg captureEnable_r;
   reg splitModeSelect_r;
   reg runControl_r;
   reg captureSourceSelect_r;
   reg externalClockSelect_r;
   reg lowByteClockSelect_r;
   reg highByteClockSelect_r;
   reg timerIrqEnable_r;

   // bus handshake
   reg ack_r;
   wire busReq;
   wire wrEn;
   wire lane0;

   assign busReq = read | write;
   // one wait cycle per request; the answer lands on the second edge
   assign waitrequest = busReq & ~ack_r;
   assign wrEn = write & ack_r;
   assign lane0 = byteenable[0];

   always @(posedge clk) begin
      if (!rst_n)
         ack_r <= 1'b0;
      else
         ack_r <= busReq & ~ack_r;
   end

   // pin synchronisers
   reg extSync1_r;
   reg extSync2_r;
   reg extPrev_r;
   reg slowSync1_r;
   reg slowSync2_r;
   reg slowPrev_r;

   always @(posedge clk) begin
      if (!rst_n) begin
         extSync1_r <= 1'b0;
         extSync2_r <= 1'b0;
         extPrev_r <= 1'b0;
         slowSync1_r <= 1'b0;
         slowSync2_r <= 1'b0;
         slowPrev_r <= 1'b0;
      end else begin
         extSync1_r <= extOsc;
         extSync2_r <= extSync1_r;
         extPrev_r <= extSync2_r;
         slowSync1_r <= slowOscillator;
         slowSync2_r <= slowSync1_r;
         slowPrev_r <= slowSync2_r;
      end
   end

   // dividers: core/12 and external/8, both as single-cycle pulses in clk domain
   reg [3:0] sysDiv_r;
   reg [2:0] extDiv_r;
   wire extRise;
   wire sysTick;
   wire extTick;

   assign extRise = extSync2_r & ~extPrev_r;
   assign sysTick = (sysDiv_r == `TMR_SYS_DIV - 4'h1);
   assign extTick = extRise & (extDiv_r == `TMR_EXT_DIV);

   always @(posedge clk) begin
      if (!rst_n) begin
         sysDiv_r <= 4'h0;
         extDiv_r <= 3'h0;
      end else begin
         sysDiv_r <= sysTick ? 4'h0 : sysDiv_r + 4'h1;
         if (extRise)
            extDiv_r <= extDiv_r + 3'h1;
      end
   end

   // mode decode
   wire captureMode;
   wire captureEvent;
   wire lowTick;
   wire highTick;
   wire lowRun;
   wire highRun;
   wire lowWrap;
   wire highWrap;

   // only source 1 is defined; source 0 makes no capture events
   assign captureMode = captureEnable_r & captureSourceSelect_r;
   assign captureEvent = captureMode & slowPrev_r & ~slowSync2_r;
   assign lowTick = selTick(lowByteClockSelect_r, externalClockSelect_r,
                            sysTick, extTick);
   assign highTick = selTick(highByteClockSelect_r, externalClockSelect_r,
                             sysTick, extTick);

   // in 16-bit mode the whole counter runs from the low byte's clock
   assign lowRun = splitModeSelect_r ? lowTick : (lowTick & runControl_r);
   assign highRun = splitModeSelect_r ? (highTick & runControl_r)
                                      : (lowRun & atTop(countLow_r));
   assign lowWrap = lowRun & atTop(countLow_r);
   assign highWrap = highRun & atTop(countHigh_r);

   // next count values
   reg [7:0] countLow_nxt;
   reg [7:0] countHigh_nxt;
   reg fullWrap;

   always @* begin
      countLow_nxt = countLow_r;
      countHigh_nxt = countHigh_r;
      fullWrap = 1'b0;
      if (!splitModeSelect_r) begin
         if (lowRun) begin
            if (lowWrap && atTop(countHigh_r)) begin
               fullWrap = 1'b1;
               if (captureMode) begin
                  countLow_nxt = 8'h00;
                  countHigh_nxt = 8'h00;
               end else begin
                  countLow_nxt = reloadLow_r;
                  countHigh_nxt = reloadHigh_r;
               end
            end else begin
               countLow_nxt = stepByte(countLow_r);
               if (lowWrap)
                  countHigh_nxt = stepByte(countHigh_r);
            end
         end
      end else begin
         if (lowRun)
            countLow_nxt = (lowWrap && !captureMode) ? reloadLow_r
                                                     : stepByte(countLow_r);
         if (highRun)
            countHigh_nxt = (highWrap && !captureMode) ? reloadHigh_r
                                                       : stepByte(countHigh_r);
      end
   end

   // flag set conditions
   wire setHighFlag;
   wire setLowFlag;

   // capture events raise the high flag so they reach the interrupt line
   assign setHighFlag = (splitModeSelect_r ? highWrap : fullWrap)
                        | captureEvent;
   assign setLowFlag = lowWrap;

   // register file
   wire wrControl;
   wire wrCountLow;
   wire wrCountHigh;
   wire wrReloadLow;
   wire wrReloadHigh;
   wire wrPrescale;
   wire wrIrqEnable;

   assign wrControl = wrHit(address, `TMR_ADDR_CONTROL, wrEn & lane0);
   assign wrCountLow = wrHit(address, `TMR_ADDR_COUNT_LOW, wrEn & lane0);
   assign wrCountHigh = wrHit(address, `TMR_ADDR_COUNT_HIGH, wrEn & lane0);
   assign wrReloadLow = wrHit(address, `TMR_ADDR_RELOAD_LOW, wrEn & lane0);
   assign wrReloadHigh = wrHit(address, `TMR_ADDR_RELOAD_HIGH, wrEn & lane0);
   assign wrPrescale = wrHit(address, `TMR_ADDR_PRESCALE, wrEn & lane0);
   assign wrIrqEnable = wrHit(address, `TMR_ADDR_IRQ_ENABLE, wrEn & lane0);

   always @(posedge clk) begin
      if (!rst_n) begin
         countLow_r <= `TMR_RESET_BYTE;
         countHigh_r <= `TMR_RESET_BYTE;
         reloadLow_r <= `TMR_RESET_BYTE;
         reloadHigh_r <= `TMR_RESET_BYTE;
         highOverflowFlag_r <= 1'b0;
         lowOverflowFlag_r <= 1'b0;
         lowByteIrqEnable_r <= 1'b0;
         captureEnable_r <= 1'b0;
         splitModeSelect_r <= 1'b0;
         runControl_r <= 1'b0;
         captureSourceSelect_r <= 1'b0;
         externalClockSelect_r <= 1'b0;
         lowByteClockSelect_r <= 1'b0;
         highByteClockSelect_r <= 1'b0;
         timerIrqEnable_r <= 1'b0;
      end else begin
         // a software write to a count byte beats a count step in the same cycle
         countLow_r <= wrCountLow ? writedata[7:0] : countLow_nxt;
         countHigh_r <= wrCountHigh ? writedata[7:0] : countHigh_nxt;
         if (captureEvent) begin
            reloadLow_r <= countLow_r;
            reloadHigh_r <= countHigh_r;
         end else begin
            if (wrReloadLow)
               reloadLow_r <= writedata[7:0];
            if (wrReloadHigh)
               reloadHigh_r <= writedata[7:0];
         end
         // hardware never clears a flag; a set in the clearing cycle wins
         if (setHighFlag)
            highOverflowFlag_r <= 1'b1;
         else if (wrControl)
            highOverflowFlag_r <= writedata[`TMR_CTL_HIGH_OVF];
         if (setLowFlag)
            lowOverflowFlag_r <= 1'b1;
         else if (wrControl)
            lowOverflowFlag_r <= writedata[`TMR_CTL_LOW_OVF];
         if (wrControl) begin
            lowByteIrqEnable_r <= writedata[`TMR_CTL_LOW_IRQ_EN];
            captureEnable_r <= writedata[`TMR_CTL_CAPTURE_EN];
            splitModeSelect_r <= writedata[`TMR_CTL_SPLIT];
            runControl_r <= writedata[`TMR_CTL_RUN];
            captureSourceSelect_r <= writedata[`TMR_CTL_CAP_SRC];
            externalClockSelect_r <= writedata[`TMR_CTL_EXT_CLK];
         end
         if (wrPrescale) begin
            lowByteClockSelect_r <= writedata[`TMR_PRE_LOW_SEL];
            highByteClockSelect_r <= writedata[`TMR_PRE_HIGH_SEL];
         end
         if (wrIrqEnable)
            timerIrqEnable_r <= writedata[`TMR_IE_TIMER];
      end
   end

   // read mux, registered during the wait cycle
   reg [7:0] readByte;

   always @* begin
      case (address)
         `TMR_ADDR_CONTROL:
            readByte = {highOverflowFlag_r, lowOverflowFlag_r, lowByteIrqEnable_r,
                        captureEnable_r, splitModeSelect_r, runControl_r,
                        captureSourceSelect_r, externalClockSelect_r};
         `TMR_ADDR_COUNT_LOW: readByte = countLow_r;
         `TMR_ADDR_COUNT_HIGH: readByte = countHigh_r;
         `TMR_ADDR_RELOAD_LOW: readByte = reloadLow_r;
         `TMR_ADDR_RELOAD_HIGH: readByte = reloadHigh_r;
         `TMR_ADDR_PRESCALE: readByte = {6'h00, highByteClockSelect_r, lowByteClockSelect_r};
         `TMR_ADDR_IRQ_ENABLE: readByte = {2'h0, timerIrqEnable_r, 5'h00};
         default: readByte = 8'h00;
      endcase
   end

   always @(posedge clk) begin
      if (!rst_n)
         readdata <= 32'h0000_0000;
      else if (read & ~ack_r)
         readdata <= {24'h00_0000, readByte};
   end

   // high flag covers full and high-byte wraps and captures; low flag only when enabled
   assign timerIrq = timerIrqEnable_r & (highOverflowFlag_r
                     | (lowByteIrqEnable_r & lowOverflowFlag_r));

endmodule // tmr_timer2

//--- logic/tmr_timer2_regs.vh
// register map, field positions, reset values and clock-divide counts of the timer
`ifndef TMR_TIMER2_REGS_VH
`define TMR_TIMER2_REGS_VH

// byte addresses on the register bus (word index = address[4:2])
`define TMR_ADDR_CONTROL 5'h00
`define TMR_ADDR_COUNT_LOW 5'h04
`define TMR_ADDR_COUNT_HIGH 5'h08
`define TMR_ADDR_RELOAD_LOW 5'h0C
`define TMR_ADDR_RELOAD_HIGH 5'h10
`define TMR_ADDR_PRESCALE 5'h14
`define TMR_ADDR_IRQ_ENABLE 5'h18

// timer_control_reg fields
`define TMR_CTL_HIGH_OVF 7
`define TMR_CTL_LOW_OVF 6
`define TMR_CTL_LOW_IRQ_EN 5
`define TMR_CTL_CAPTURE_EN 4
`define TMR_CTL_SPLIT 3
`define TMR_CTL_RUN 2
`define TMR_CTL_CAP_SRC 1
`define TMR_CTL_EXT_CLK 0

// clock_prescale_reg fields
`define TMR_PRE_LOW_SEL 0
`define TMR_PRE_HIGH_SEL 1

// interrupt_enable_reg field
`define TMR_IE_TIMER 5

// reset values
`define TMR_RESET_BYTE 8'h00

// clock dividers
`define TMR_SYS_DIV 4'hC
`define TMR_EXT_DIV 3'h7

`endif

//--- verification/tmr_timer2_monitor.sv
// concurrent checks on the timer's register port and interrupt pin
`timescale 1ns/1ps
`include "tmr_timer2_regs.vh"
module tmr_timer2_monitor (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // register bus
   input wire [4:0] address,
   input wire read,
   input wire write,
   input wire [31:0] writedata,
   input wire [3:0] byteenable,
   input wire [31:0] readdata,
   input wire waitrequest,
   // pins
   input wire extOsc,
   input wire slowOscillator,
   input wire timerIrq
);
   reg ieOn_r;
   reg capOn_r;
   wire wrDone = write && !waitrequest && byteenable[0];
   // shadows of software-owned enables, updated on the same edge as the design
   always @(posedge clk) begin
      if (!rst_n) begin
         ieOn_r <= 1'b0;
         capOn_r <= 1'b0;
      end else if (wrDone && address == `TMR_ADDR_IRQ_ENABLE) begin
         ieOn_r <= writedata[`TMR_IE_TIMER];
      end else if (wrDone && address == `TMR_ADDR_CONTROL) begin
         capOn_r <= writedata[`TMR_CTL_CAPTURE_EN] && writedata[`TMR_CTL_CAP_SRC];
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_read_wait: assert property ($rose(read) |-> waitrequest ##1 !waitrequest)
      else $error("read answer not after one wait cycle");
   a_write_wait: assert property ($rose(write) |-> waitrequest ##1 !waitrequest)
      else $error("write answer not after one wait cycle");
   a_idle_no_wait: assert property (!(read || write) |-> !waitrequest)
      else $error("waitrequest raised without request");
   a_read_upper: assert property (
      read && !waitrequest |-> readdata[31:8] == 24'h00_0000)
      else $error("read data upper bits not zero");
   a_data_stands: assert property ($changed(readdata) |-> $past(read && waitrequest))
      else $error("read data changed outside a read");
   a_irq_enable: assert property (!ieOn_r |-> !timerIrq)
      else $error("interrupt raised while disabled");
   a_flag_sticky: assert property ($fell(timerIrq) |-> $past(write && !waitrequest))
      else $error("interrupt dropped without software write");
   a_capture_irq: assert property (
      $fell(slowOscillator) && ieOn_r && capOn_r |-> ##[1:6] timerIrq)
      else $error("capture event raised no interrupt");
endmodule // tmr_timer2_monitor

bind tmr_timer2 tmr_timer2_monitor tmr_timer2_monitor_inst (.clk(clk), .rst_n(rst_n),
   .address(address), .read(read), .write(write), .writedata(writedata),
   .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
   .extOsc(extOsc), .slowOscillator(slowOscillator), .timerIrq(timerIrq));

//--- verification/tmr_testbench.sv
// self-checking bench driving the timer through its register port
`timescale 1ns/1ps
`include "tmr_timer2_regs.vh"
module testbench;
   localparam [4:0] aCtl = `TMR_ADDR_CONTROL;
   localparam [4:0] aLo = `TMR_ADDR_COUNT_LOW;
   localparam [4:0] aHi = `TMR_ADDR_COUNT_HIGH;
   localparam [4:0] aRlL = `TMR_ADDR_RELOAD_LOW;
   localparam [4:0] aRlH = `TMR_ADDR_RELOAD_HIGH;
   localparam [4:0] aPre = `TMR_ADDR_PRESCALE;
   localparam [4:0] aIe = `TMR_ADDR_IRQ_ENABLE;
   reg clk, rst_n, read, write, extOsc, slowOscillator, extRun;
   reg [4:0] address;
   reg [31:0] writedata;
   reg [3:0] byteenable;
   reg [31:0] rd;
   wire [31:0] readdata;
   wire waitrequest, timerIrq;
   integer nErrors, testsRun, i;
   tmr_timer2 tmr_timer2_inst (.clk(clk), .rst_n(rst_n), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .extOsc(extOsc), .slowOscillator(slowOscillator),
      .timerIrq(timerIrq));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // external oscillator at half the core rate, one rising edge every two clocks
   always @(posedge clk) begin
      if (extRun)
         extOsc <= ~extOsc;
      else
         extOsc <= 1'b0;
   end
   task close_out;
      begin
         $display("checks %0d mismatches %0d", testsRun, nErrors);
         if (nErrors == 0 && testsRun > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask
   task check(input string s, input [31:0] seen, input [31:0] exp);
      begin
         testsRun = testsRun + 1;
         if (seen !== exp) begin
            nErrors = nErrors + 1;
            $display("mismatch %0s expected %h seen %h", s, exp, seen);
         end
      end
   endtask
   // waitrequest and read data are sampled at the rising edge, before its updates land
   task bus(input isWr, input [4:0] a, input [7:0] d);
      integer k;
      begin
         @(posedge clk);
         read <= !isWr;
         write <= isWr;
         address <= a;
         writedata <= {24'h00_0000, d};
         k = 0;
         @(posedge clk);
         while (waitrequest !== 1'b0 && k < 20) begin
            k = k + 1;
            @(posedge clk);
         end
         if (k == 20) begin
            nErrors = nErrors + 1;
            close_out;
         end else begin
            rd = readdata;
            read <= 1'b0;
            write <= 1'b0;
         end
      end
   endtask
   task wr(input [4:0] a, input [7:0] d);
      bus(1'b1, a, d);
   endtask
   task rc(input string s, input [4:0] a, input [31:0] e);
      begin
         bus(1'b0, a, 8'h00);
         check(s, rd, e);
      end
   endtask
   task irq(input e);
      begin
         @(posedge clk);
         check("irq", {31'h0000_0000, timerIrq}, {31'h0000_0000, e});
      end
   endtask
   task idle(input integer n);
      repeat (n) @(posedge clk);
   endtask
   initial begin
      {rst_n, read, write, extRun} = 4'h0;
      slowOscillator = 1'b1;
      address = 5'h00;
      writedata = 32'h0000_0000;
      byteenable = 4'hF;
      nErrors = 0;
      testsRun = 0;
      idle(12);
      rst_n <= 1'b1;
      for (i = 0; i < 8; i = i + 1)
         rc("reset", 5'(i * 4), 32'h0000_0000);
      for (i = 1; i < 5; i = i + 1) begin
         wr(5'(i * 4), 8'(i * 8'h31));
         rc("rw", 5'(i * 4), 32'(i * 8'h31));
      end
      byteenable <= 4'hE;
      wr(aLo, 8'hFF);
      byteenable <= 4'hF;
      rc("byteEnable", aLo, 32'h0000_0031);
      wr(5'h1C, 8'hFF);
      rc("hole", 5'h1C, 32'h0000_0000);
      wr(aPre, 8'h01);
      wr(aLo, 8'hF0);
      wr(aHi, 8'hFF);
      wr(aRlL, 8'h00);
      wr(aRlH, 8'hAB);
      wr(aCtl, 8'h04);
      idle(20);
      rc("wrapFlags", aCtl, 32'h0000_00C4);
      rc("reloadHigh", aHi, 32'h0000_00AB);
      irq(1'b0);
      wr(aIe, 8'h20);
      irq(1'b1);
      idle(40);
      rc("sticky", aCtl, 32'h0000_00C4);
      wr(aCtl, 8'h00);
      irq(1'b0);
      wr(aLo, 8'h77);
      idle(30);
      rc("hold", aLo, 32'h0000_0077);
      wr(aPre, 8'h03);
      wr(aLo, 8'hF8);
      wr(aHi, 8'hF8);
      wr(aRlL, 8'h40);
      wr(aRlH, 8'h50);
      wr(aCtl, 8'h08);
      idle(20);
      rc("splitLow", aCtl, 32'h0000_0048);
      rc("splitGate", aHi, 32'h0000_00F8);
      irq(1'b0);
      wr(aCtl, 8'h68);
      irq(1'b1);
      wr(aCtl, 8'h0C);
      idle(12);
      bus(1'b0, aCtl, 8'h00);
      check("splitHigh", rd[7], 1);
      bus(1'b0, aHi, 8'h00);
      check("splitReload", rd[7:4], 4'h5);
      wr(aCtl, 8'h00);
      wr(aPre, 8'h00);
      wr(aLo, 8'h00);
      wr(aCtl, 8'h04);
      idle(120);
      wr(aCtl, 8'h00);
      bus(1'b0, aLo, 8'h00);
      check("div12", rd >= 9 && rd <= 11, 1);
      extRun <= 1'b1;
      wr(aLo, 8'h00);
      wr(aCtl, 8'h05);
      idle(160);
      wr(aCtl, 8'h01);
      bus(1'b0, aLo, 8'h00);
      check("ext8", rd >= 9 && rd <= 11, 1);
      wr(aLo, 8'h56);
      wr(aHi, 8'h34);
      wr(aCtl, 8'h12);
      slowOscillator <= 1'b0;
      idle(8);
      rc("captureLow", aRlL, 32'h0000_0056);
      rc("captureHigh", aRlH, 32'h0000_0034);
      irq(1'b1);
      slowOscillator <= 1'b1;
      wr(aCtl, 8'h02);
      wr(aLo, 8'h99);
      slowOscillator <= 1'b0;
      idle(8);
      rc("captureOff", aRlL, 32'h0000_0056);
      slowOscillator <= 1'b1;
      wr(aHi, 8'h21);
      wr(aCtl, 8'h1A);
      slowOscillator <= 1'b0;
      idle(8);
      rc("captureSplit", aRlH, 32'h0000_0021);
      close_out;
   end
endmodule // testbench
